// ### dualrm_map.svh
// constants of the dual-read flip-flop ram: config pin bits, register map, reset values
// assumes inclusion by bare name from the top design file; the package does not include it
`ifndef DUALRM_MAP_SVH
`define DUALRM_MAP_SVH

// captured configuration bits on the shared input lines
`define DUALRM_CFG_PAGE      0
`define DUALRM_CFG_RDREG_A   4
`define DUALRM_CFG_RDREG_B   5
`define DUALRM_CFG_WTHRU     6
// port b address, both half selects and the write enable on the shared input lines during operation
`define DUALRM_SH_ADDR_B_LSB 0
`define DUALRM_SH_HALF_A     4
`define DUALRM_SH_HALF_B     5
`define DUALRM_SH_WEN        7

// register byte offsets
`define DUALRM_REG_CONFIG    12'h000
`define DUALRM_REG_CONTROL   12'h004
`define DUALRM_REG_STATUS    12'h008
`define DUALRM_ADDR_LSBS     12

// control register fields and reset
`define DUALRM_CTRL_WBLOCK   0
`define DUALRM_CTRL_RESET    1'h0
// status register fields
`define DUALRM_ST_RDA_LSB    0
`define DUALRM_ST_RDB_LSB    4
`define DUALRM_ST_CAPTURED   8

// ahb encodings
`define DUALRM_HTRANS_NONSEQ 2'h2
`define DUALRM_HRESP_OKAY    1'h0

`endif

// ### dualrm_pkg.sv
// types shared by the dual-read flip-flop ram, its controller model, checker and bench
// assumes dualrm_map.svh for numeric constants
package dualrm_pkg;

  // port a request lines as they arrive on the dedicated inputs
  typedef struct packed {
    logic [3:0] addr;
    logic [3:0] write_data;
  } dualrm_port_a_t;

  // configuration caught at reset release
  typedef struct packed {
    logic page_select;
    logic rdreg_a;
    logic rdreg_b;
    logic wthru;
  } dualrm_cfg_t;

  // captured ahb address phase
  typedef struct packed {
    logic        valid;
    logic        write;
    logic [11:0] addr;
  } dualrm_ahb_req_t;

endpackage

// ### dualrm_read_port.sv
// one read port: nibble select, write-through bypass, optional output register
// assumes the byte given is already the addressed one of the active page
`timescale 1ns/1ps
`default_nettype none
module dualrm_read_port #(
  parameter int unsigned DATA_W = 8
) (
  input  wire logic                hclk,
  input  wire logic                hresetn,
  input  wire logic [DATA_W-1:0]   byte_value,
  input  wire logic                half_select,
  input  wire logic                bypass,
  input  wire logic [DATA_W/2-1:0] bypass_value,
  input  wire logic                registered,
  output logic      [DATA_W/2-1:0] read_data
);
  logic [DATA_W/2-1:0] nibble;
  logic [DATA_W/2-1:0] held;
  logic [DATA_W/2-1:0] next_held;

  // nibble pick, then the bypass of the value being written
  always_comb begin
    nibble = half_select ? byte_value[DATA_W-1:DATA_W/2] : byte_value[DATA_W/2-1:0];
    if (bypass) begin
      nibble = bypass_value;
    end
    next_held = nibble;
  end

  // output register loads every cycle, so it shows last cycle's read
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      held <= '0;
    end else begin
      held <= next_held;
    end
  end

  // no read enable: the port always shows data
  assign read_data = registered ? held : nibble;
endmodule
`default_nettype wire

// ### dualrm_top.sv
// dual-read single-write flip-flop ram with an ahb-lite status and control slave
// assumes synchronous inputs, one clock, shared lines driven by an outside controller
//
// The placing of the registers and the AHB-Lite interface to the registers are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "dualrm_map.svh"
module dualrm_top #(
  parameter int unsigned DATA_W    = 8,
  parameter int unsigned ADDR_W    = 4,
  parameter int unsigned PAGES     = 2
) (
  input  wire logic                  hclk,
  input  wire logic                  hresetn,
  input  wire dualrm_pkg::dualrm_port_a_t port_a_in,
  input  wire logic [7:0]            shared_in,
  output logic      [7:0]            shared_out,
  output logic      [7:0]            shared_oe,
  output logic      [DATA_W/2-1:0]   port_a_read_data,
  output logic      [DATA_W/2-1:0]   port_b_read_data,
  input  wire logic                  hsel,
  input  wire logic [31:0]           haddr,
  input  wire logic [1:0]            htrans,
  input  wire logic                  hwrite,
  input  wire logic [2:0]            hsize,
  input  wire logic [31:0]           hwdata,
  input  wire logic                  hready,
  output logic                       hreadyout,
  output logic                       hresp,
  output logic      [31:0]           hrdata
);
  localparam int unsigned DEPTH = PAGES * (1 << ADDR_W);
  localparam int unsigned FULL_W = ADDR_W + 1;

  // storage, deliberately outside the reset net
  logic [DATA_W-1:0] mem [DEPTH];

  // captured configuration
  dualrm_pkg::dualrm_cfg_t cfg;
  dualrm_pkg::dualrm_cfg_t next_cfg;
  logic                    captured;
  logic                    next_captured;

  // software control and ahb state
  logic                        write_block;
  logic                        next_write_block;
  dualrm_pkg::dualrm_ahb_req_t req;
  dualrm_pkg::dualrm_ahb_req_t next_req;
  logic [31:0]                 next_hrdata;

  // decoded port lines
  logic [ADDR_W-1:0] addr_b;
  logic              half_a;
  logic              half_b;
  logic              wen;
  logic              write_go;
  logic [FULL_W-1:0] full_a;
  logic [FULL_W-1:0] full_b;
  logic [DATA_W-1:0] byte_a;
  logic [DATA_W-1:0] byte_b;
  logic              bypass_a;
  logic              bypass_b;

  // the shared lines are inputs only, never driven
  assign shared_out = 8'h00;
  assign shared_oe  = 8'h00;

  // port b address and the control lines travel on the shared inputs
  always_comb begin
    addr_b = shared_in[`DUALRM_SH_ADDR_B_LSB +: ADDR_W];
    half_a = shared_in[`DUALRM_SH_HALF_A];
    half_b = shared_in[`DUALRM_SH_HALF_B];
    wen    = shared_in[`DUALRM_SH_WEN];
  end

  // page bit from the captured config on top of the pin address
  always_comb begin
    full_a   = {cfg.page_select, port_a_in.addr};
    full_b   = {cfg.page_select, addr_b};
    write_go = wen && !write_block;
    byte_a   = mem[full_a];
    byte_b   = mem[full_b];
    bypass_a = cfg.wthru && write_go;
    bypass_b = cfg.wthru && write_go && (full_b == full_a) && (half_b == half_a);
  end

  // configuration is caught once, at the first edge after reset release;
  // a flop under async reset may only take a constant, hence the flag
  always_comb begin
    next_cfg      = cfg;
    next_captured = 1'b1;
    if (!captured) begin
      next_cfg.page_select = shared_in[`DUALRM_CFG_PAGE];
      next_cfg.rdreg_a     = shared_in[`DUALRM_CFG_RDREG_A];
      next_cfg.rdreg_b     = shared_in[`DUALRM_CFG_RDREG_B];
      next_cfg.wthru       = shared_in[`DUALRM_CFG_WTHRU];
      // bits 3..1 and 7 are not looked at: bit 7 is the write enable
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      cfg      <= '0;
      captured <= 1'b0;
    end else begin
      cfg      <= next_cfg;
      captured <= next_captured;
    end
  end

  // no writes until the config is in, so a free-running clock cannot slip one in
  always_ff @(posedge hclk) begin
    if (write_go && captured) begin
      if (half_a) begin
        mem[full_a][DATA_W-1:DATA_W/2] <= port_a_in.write_data;
      end else begin
        mem[full_a][DATA_W/2-1:0] <= port_a_in.write_data;
      end
    end
  end

  // both read ports share one structure
  dualrm_read_port #(
    .DATA_W (DATA_W)
  ) u_port_a (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .byte_value   (byte_a),
    .half_select  (half_a),
    .bypass       (bypass_a && captured),
    .bypass_value (port_a_in.write_data),
    .registered   (cfg.rdreg_a),
    .read_data    (port_a_read_data)
  );

  dualrm_read_port #(
    .DATA_W (DATA_W)
  ) u_port_b (
    .hclk         (hclk),
    .hresetn      (hresetn),
    .byte_value   (byte_b),
    .half_select  (half_b),
    .bypass       (bypass_b && captured),
    .bypass_value (port_a_in.write_data),
    .registered   (cfg.rdreg_b),
    .read_data    (port_b_read_data)
  );

  // ahb-lite slave: zero wait states, always okay
  assign hreadyout = 1'b1;
  assign hresp     = `DUALRM_HRESP_OKAY;

  // address phase capture, data phase write, read data loaded ahead of the data phase
  always_comb begin
    next_req         = '0;
    next_write_block = write_block;
    next_hrdata      = hrdata;
    if (req.valid && req.write && req.addr == `DUALRM_REG_CONTROL) begin
      next_write_block = hwdata[`DUALRM_CTRL_WBLOCK];
    end
    if (hsel && hready && htrans == `DUALRM_HTRANS_NONSEQ) begin
      next_req.valid = 1'b1;
      next_req.write = hwrite;
      next_req.addr  = haddr[`DUALRM_ADDR_LSBS-1:0];
      if (!hwrite) begin
        next_hrdata = 32'h0000_0000; // unmapped reads give zero
        unique case (haddr[`DUALRM_ADDR_LSBS-1:0])
          `DUALRM_REG_CONFIG: begin
            next_hrdata[`DUALRM_CFG_PAGE]    = cfg.page_select;
            next_hrdata[`DUALRM_CFG_RDREG_A] = cfg.rdreg_a;
            next_hrdata[`DUALRM_CFG_RDREG_B] = cfg.rdreg_b;
            next_hrdata[`DUALRM_CFG_WTHRU]   = cfg.wthru;
          end
          `DUALRM_REG_CONTROL: begin
            next_hrdata[`DUALRM_CTRL_WBLOCK] = next_write_block;
          end
          `DUALRM_REG_STATUS: begin
            next_hrdata[`DUALRM_ST_RDA_LSB +: DATA_W/2] = port_a_read_data;
            next_hrdata[`DUALRM_ST_RDB_LSB +: DATA_W/2] = port_b_read_data;
            next_hrdata[`DUALRM_ST_CAPTURED]            = captured;
          end
          default: begin
            next_hrdata = 32'h0000_0000;
          end
        endcase
      end
    end
  end

  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      req         <= '0;
      write_block <= `DUALRM_CTRL_RESET;
      hrdata      <= 32'h0000_0000;
    end else begin
      req         <= next_req;
      write_block <= next_write_block;
      hrdata      <= next_hrdata;
    end
  end
endmodule
`default_nettype wire

// ### dualrm_ctl_model.sv
// controller model: drives the ram address, data, half select and enable lines
// assumes its tasks are called right after a rising clock edge
`timescale 1ns/1ps
`default_nettype none
module dualrm_ctl_model (
  output var dualrm_pkg::dualrm_port_a_t port_a_in,
  output var logic [7:0]                 shared_in
);
  // quiet start: no enable, both ports at address 0
  initial begin
    port_a_in = '0;
    shared_in = 8'h00;
  end
  // one beat of port levels; bit 6 stays low since it only matters at release
  task automatic put(input logic [3:0] aa, d, input logic ha, input logic [3:0] ab, input logic hb, we);
    port_a_in <= '{aa, d};
    shared_in <= {we, 1'b0, hb, ha, ab};
  endtask
  // option levels, held by the caller over the reset release edge
  task automatic cfg(input logic [7:0] c);
    shared_in <= c;
  endtask
endmodule
`default_nettype wire

// ### dualrm_top_asserts.sv
// checker for the flop ram top: cross-port reads, bypass and write timing
// assumes one clock, active-low reset, options caught at first edge after release
`timescale 1ns/1ps
`default_nettype none
module dualrm_chk #(parameter int unsigned DATA_W = 8) (
  input wire logic                       hclk,
  input wire logic                       hresetn,
  input wire dualrm_pkg::dualrm_port_a_t port_a_in,
  input wire logic [7:0]                 shared_in,
  input wire logic [7:0]                 shared_oe,
  input wire logic [7:0]                 shared_out,
  input wire logic [DATA_W/2-1:0]        port_a_read_data,
  input wire logic [DATA_W/2-1:0]        port_b_read_data,
  input wire logic                       hsel,
  input wire logic [31:0]                haddr,
  input wire logic [1:0]                 htrans,
  input wire logic                       hwrite,
  input wire logic                       hready,
  input wire logic [31:0]                hwdata
);
  logic       cap, cap_q, ra, rb, wt, blk, ap, wr_q, same_q;
  logic [3:0] wd_q;
  wire logic  wen  = shared_in[7];
  wire logic  same = port_a_in.addr == shared_in[3:0] && shared_in[4] == shared_in[5];
  // own copy of the options; write block snooped off the bus, no register read needed
  always_ff @(posedge hclk or negedge hresetn) begin
    if (!hresetn) begin
      {cap, cap_q, ra, rb, wt, blk, ap, wr_q, same_q} <= '0;
      wd_q <= '0;
    end else begin
      if (!cap) {wt, rb, ra} <= shared_in[6:4];
      cap <= 1'b1;
      cap_q <= cap;
      ap <= hsel && hready && htrans == 2'h2 && hwrite && haddr[11:0] == 12'h004;
      if (ap) blk <= hwdata[0];
      wr_q <= cap && wen && !blk;
      wd_q <= port_a_in.write_data;
      same_q <= same;
    end
  end
  default clocking @(posedge hclk); endclocking
  default disable iff (!hresetn);
  chk_dual_equal: assert property (cap && !ra && !rb && same |-> port_a_read_data == port_b_read_data)
    else $error("ports differ at one location");
  chk_rega_delay: assert property (cap_q && ra && !rb && same_q |-> port_a_read_data == $past(port_b_read_data))
    else $error("port a not one cycle late");
  chk_regb_delay: assert property (cap_q && rb && !ra && same_q |-> port_b_read_data == $past(port_a_read_data))
    else $error("port b not one cycle late");
  chk_both_reg: assert property (cap_q && ra && rb && same_q |-> port_a_read_data == port_b_read_data)
    else $error("registered ports differ");
  chk_no_drive: assert property (shared_oe == 8'h00 && shared_out == 8'h00)
    else $error("shared lines driven");
  chk_wthru_a: assert property (cap && wt && !ra && wen && !blk |-> port_a_read_data == port_a_in.write_data)
    else $error("port a bypass missing");
  chk_wthru_b: assert property (cap && wt && !rb && wen && !blk && same |-> port_b_read_data == port_a_in.write_data)
    else $error("port b bypass missing");
  chk_write_lands: assert property (wr_q && !ra && !(wt && wen) && $stable(port_a_in.addr) && $stable(shared_in[4])
    |-> port_a_read_data == wd_q)
    else $error("write not stored");
endmodule
bind dualrm_top dualrm_chk #(.DATA_W(DATA_W)) chk_i (.hclk, .hresetn, .port_a_in, .shared_in, .shared_oe, .shared_out,
  .port_a_read_data, .port_b_read_data, .hsel, .haddr, .htrans, .hwrite, .hready, .hwdata);
`default_nettype wire

// ### tb_top.sv
// self-checking bench for the dual-read flop ram
// assumes dualrm_ctl_model drives the ram lines and the checker is bound
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic                       hclk, hresetn, hsel, hwrite;
  logic [31:0]                haddr, hwdata, hrdata;
  logic [1:0]                 htrans;
  logic [2:0]                 hsize;
  wire logic                  hready;
  wire logic                  hresp;
  wire logic [3:0]            rd_a, rd_b;
  dualrm_pkg::dualrm_port_a_t port_a_in;
  logic [7:0]                 shared_in;
  int                         err_total, comparisons;
  dualrm_top DUT (.hclk, .hresetn, .port_a_in, .shared_in, .shared_out(), .shared_oe(),
    .port_a_read_data(rd_a), .port_b_read_data(rd_b), .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata, .hready, .hreadyout(hready), .hresp(hresp), .hrdata);
  dualrm_ctl_model ctl (.port_a_in, .shared_in);
  initial begin
    hclk = 1'b0;
    forever #5 hclk = ~hclk;
  end
  // stored nibble pattern, distinct per page and half
  function automatic logic [3:0] nib(input logic p, input logic [3:0] a, input logic h);
    return a ^ {h, p, 2'h2};
  endfunction
  task automatic close_out;
    $display("comparisons=%0d err_total=%0d", comparisons, err_total);
    if (err_total == 0 && comparisons > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      err_total++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // bounded wait for hready at a rising edge
  task automatic wait_rdy;
    int n;
    n = 0;
    @(posedge hclk);
    while (hready !== 1'b1) begin
      n++;
      if (n > 50) begin
        err_total++;
        close_out;
      end
      @(posedge hclk);
    end
  endtask
  task automatic ahb(input logic w, input logic [11:0] a, input logic [31:0] wd, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {20'h0, a};
    htrans <= 2'h2;
    hwrite <= w;
    wait_rdy;
    hsel <= 1'b0;
    htrans <= 2'h0;
    hwdata <= wd;
    wait_rdy;
    rd = hrdata;
    chk(hresp, 32'h0);
  endtask
  // reset with option levels held over release, then check the captured copy
  task automatic boot(input logic [7:0] c);
    logic [31:0] r;
    hresetn <= 1'b0;
    ctl.cfg(c);
    repeat (6) @(posedge hclk);
    hresetn <= 1'b1;
    @(posedge hclk);
    ctl.put(4'h0, 4'h0, 1'b0, 4'h1, 1'b0, 1'b0);
    @(posedge hclk);
    ahb(1'b0, 12'h000, 32'h0, r);
    chk(r, {25'h0, c[6:4], 3'h0, c[0]});
  endtask
  // port b kept on address a ^ 1, off the written one, so the same-location checks stay out of the write; it may read an unwritten byte
  task automatic wr(input logic [3:0] a, input logic h, input logic [3:0] d);
    ctl.put(a, d, h, a ^ 4'h1, 1'b0, 1'b1);
    @(posedge hclk);
  endtask
  task automatic rd(input logic [3:0] a, input logic h, input logic [3:0] e);
    ctl.put(a, 4'h0, h, a, h, 1'b0);
    @(posedge hclk);
    #1;
    chk(rd_a, e);
    chk(rd_b, e);
    @(posedge hclk);
  endtask
  task automatic t_fill(input logic p);
    boot({7'h0, p});
    for (int i = 0; i < 32; i++) wr(i[3:0], i[4], nib(p, i[3:0], i[4]));
    for (int i = 0; i < 32; i++) rd(i[3:0], i[4], nib(p, i[3:0], i[4]));
    $display("fill done");
  endtask
  task automatic t_keep(input logic [7:0] c);
    boot(c);
    for (int i = 0; i < 32; i++) rd(i[3:0], i[4], nib(1'b0, i[3:0], i[4]));
    $display("keep done");
  endtask
  task automatic t_block;
    logic [31:0] r;
    ahb(1'b1, 12'h004, 32'h1, r);
    ahb(1'b0, 12'h004, 32'h0, r);
    chk(r, 32'h1);
    wr(4'h3, 1'b0, 4'h0);
    rd(4'h3, 1'b0, nib(1'b0, 4'h3, 1'b0));
    ahb(1'b0, 12'h008, 32'h0, r);
    chk(r, {23'h0, 1'b1, {2{nib(1'b0, 4'h3, 1'b0)}}});
    ahb(1'b1, 12'h004, 32'h0, r);
    ahb(1'b0, 12'h00c, 32'h0, r);
    chk(r, 32'h0);
    $display("block done");
  endtask
  task automatic t_regs;
    boot(8'h30);
    rd(4'h2, 1'b1, nib(1'b0, 4'h2, 1'b1));
    ctl.put(4'h7, 4'h0, 1'b0, 4'h7, 1'b0, 1'b0);
    #1;
    chk(rd_a, nib(1'b0, 4'h2, 1'b1));
    chk(rd_b, nib(1'b0, 4'h2, 1'b1));
    @(posedge hclk);
    #1;
    chk(rd_a, nib(1'b0, 4'h7, 1'b0));
    @(posedge hclk);
    $display("regs done");
  endtask
  task automatic t_wthru(input logic [7:0] c, input logic [3:0] d, input logic [3:0] e);
    boot(c);
    ctl.put(4'h5, d, 1'b0, 4'h5, 1'b0, 1'b1);
    #1;
    chk(rd_a, e);
    chk(rd_b, e);
    @(posedge hclk);
    rd(4'h5, 1'b0, d);
    $display("bypass done");
  endtask
  initial begin
    hresetn = 1'b0;
    hsel = 1'b0;
    hwrite = 1'b0;
    haddr = 32'h0;
    hwdata = 32'h0;
    htrans = 2'h0;
    hsize = 3'h2;
    err_total = 0;
    comparisons = 0;
    t_fill(1'b0);
    t_keep(8'h8e);
    t_fill(1'b1);
    t_keep(8'h10);
    t_keep(8'h20);
    t_block;
    t_regs;
    t_wthru(8'h40, 4'h9, 4'h9);
    t_wthru(8'h00, 4'h4, 4'h9);
    close_out;
  end
endmodule
`default_nettype wire
